// File: inc/rtcirq_pkg.sv
package rtcirq_pkg;

   typedef enum logic [0:0] {WR_IDLE, WR_RESP} rtcirq_wr_t;

   typedef struct packed {
      logic xt_q;
      logic [12:0] gap;
      logic slow;
      logic [20:0] slow_cnt;
      logic failed;
   } rtcirq_xt_t;

   typedef struct packed {
      rtcirq_wr_t wr_st;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [5:0] status;
      logic osc_fail;
      logic autocal_fail;
      logic [7:0] irq_on;
      logic [1:0] out1_sel;
      logic [1:0] out2_sel;
      logic auto_clear;
      logic in1_pol;
      logic in2_pol;
      logic bat_pol;
      logic [1:0] bat_sel;
      logic [1:0] sqw_sel;
      logic osc_req;
      logic fail_over;
      logic [1:0] autocal_interval;
      logic [1:0] alarm_pm;
      logic cd_pm;
      logic [1:0] cd_clk;
      logic cd_rpt;
      logic cd_run;
      logic [2:0] alarm_scope;
      logic wd_steer;
      logic [4:0] wd_period;
      logic in1_sel_q;
      logic in2_sel_q;
      logic bat_q;
      logic xt_failed_q;
      logic [35:0] autocal_interval_cnt;
      logic autocal_interval_start;
      logic cal_load;
      logic [11:0] alarm_pcnt;
      logic [11:0] cd_pcnt;
      logic wd_reset;
      logic use_rc;
      logic pin1;
      logic pin2;
      logic pin_cd;
      logic pin_clk;
   } rtcirq_state_t;

endpackage

// File: inc/rtcirq_regs.svh
`ifndef RTCIRQ_REGS_SVH
`define RTCIRQ_REGS_SVH

// Clock and timing
`define RTCIRQ_CLK_HZ 40_000_000
`define RTCIRQ_XT_MIN_HZ 8_000
`define RTCIRQ_XT_FAIL_MS 32
`define RTCIRQ_AUTOCAL_INTERVAL_LONG_S 1024
`define RTCIRQ_AUTOCAL_INTERVAL_SHORT_S 512
`define RTCIRQ_XT_GAP_CYC (`RTCIRQ_CLK_HZ / `RTCIRQ_XT_MIN_HZ)
`define RTCIRQ_XT_FAIL_CYC (`RTCIRQ_CLK_HZ / 1000 * `RTCIRQ_XT_FAIL_MS)
`define RTCIRQ_AUTOCAL_INTERVAL_LONG_CYC (64'(`RTCIRQ_AUTOCAL_INTERVAL_LONG_S) * 64'(`RTCIRQ_CLK_HZ))
`define RTCIRQ_AUTOCAL_INTERVAL_SHORT_CYC (64'(`RTCIRQ_AUTOCAL_INTERVAL_SHORT_S) * 64'(`RTCIRQ_CLK_HZ))

// Interrupt pulse widths, least times rounded up to whole cycles
`define RTCIRQ_PULSE0_NS 250
`define RTCIRQ_PULSE1_NS 1_000
`define RTCIRQ_PULSE2_NS 8_000
`define RTCIRQ_PULSE3_NS 64_000
`define RTCIRQ_NS2CYC(t) (((t) * (`RTCIRQ_CLK_HZ / 1_000_000) + 999) / 1000)
`define RTCIRQ_PULSE0_CYC `RTCIRQ_NS2CYC(`RTCIRQ_PULSE0_NS)
`define RTCIRQ_PULSE1_CYC `RTCIRQ_NS2CYC(`RTCIRQ_PULSE1_NS)
`define RTCIRQ_PULSE2_CYC `RTCIRQ_NS2CYC(`RTCIRQ_PULSE2_NS)
`define RTCIRQ_PULSE3_CYC `RTCIRQ_NS2CYC(`RTCIRQ_PULSE3_NS)

// Register byte offsets
`define RTCIRQ_OFF_STATUS 8'h00
`define RTCIRQ_OFF_OSCSTAT 8'h04
`define RTCIRQ_OFF_IRQEN 8'h08
`define RTCIRQ_OFF_CTRL 8'h0C
`define RTCIRQ_OFF_OSCCTRL 8'h10
`define RTCIRQ_OFF_TMRCTRL 8'h14
`define RTCIRQ_OFF_PINLVL 8'h18

// Status flag positions (also enable positions)
`define RTCIRQ_F_ALARM 0
`define RTCIRQ_F_CDOWN 1
`define RTCIRQ_F_WDOG 2
`define RTCIRQ_F_BATLO 3
`define RTCIRQ_F_IN1 4
`define RTCIRQ_F_IN2 5
`define RTCIRQ_F_OSCF 6
`define RTCIRQ_F_ACALF 7

// Autocalibration interval codes
`define RTCIRQ_AUTOCAL_INTERVAL_OFF 2'h0
`define RTCIRQ_AUTOCAL_INTERVAL_LONG 2'h2
`define RTCIRQ_AUTOCAL_INTERVAL_SHORT 2'h3

// Reset values, enable mask and response codes
`define RTCIRQ_RST_OUT1 2'h1
`define RTCIRQ_RST_OUT2 2'h0
`define RTCIRQ_IRQEN_MASK 8'hFB
`define RTCIRQ_RESP_OKAY 2'h0
`define RTCIRQ_RESP_SLVERR 2'h2

`endif

// File: src/rtcirq_top.sv
`timescale 1ns/1ps
`include "rtcirq_regs.svh"

// What this block does
// - Interval code picks off, reserved, 1024s, 512s
// - Leaving code 00 starts one calibration
// - Failed calibration sets flag, blocks RC load
// - Crystal below 8 kHz over 32 ms fails
// - Oscillator-fail flag set on failure, power-up
// - Not-running bit high when slow or RC
// - Fail-over switches to RC, back on restart
// - Indicator shows oscillator actually in use
// - Enabled flags ORed, steered to chosen pins
// - No pin interrupt without its enable, except the armed watchdog
// - Watchdog steers to interrupt or reset
// - Level sources hold until software clears
// - Alarm match sets flag, pulse mode shapes
// - Countdown zero sets flag when running
// - Countdown always on its pin, optionally clock-out
// - Battery crossing in chosen direction sets flag
// - Selected pin edges set external flags
// - Live levels of both input pins readable
// - Writing zero clears flag, bit by bit
// - Auto-clear read returns then clears, race-free
// - Select bit: 0 crystal, 1 RC
module rtcirq_top #(
   parameter logic [35:0] AUTOCAL_INTERVAL_LONG_CYC = 36'(`RTCIRQ_AUTOCAL_INTERVAL_LONG_CYC),
   parameter logic [35:0] AUTOCAL_INTERVAL_SHORT_CYC = 36'(`RTCIRQ_AUTOCAL_INTERVAL_SHORT_CYC),
   parameter logic [12:0] XT_GAP_CYC = 13'(`RTCIRQ_XT_GAP_CYC),
   parameter logic [20:0] XT_FAIL_CYC = 21'(`RTCIRQ_XT_FAIL_CYC)
) (
   input wire logic REF_CLK,
   input wire logic RSTN,
   // AXI4-Lite slave
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY,
   // Events and levels from neighbouring blocks and pins
   input wire logic ALARM_MATCH,
   input wire logic COUNTDOWN_ZERO,
   input wire logic WATCHDOG_TIMEOUT,
   input wire logic BATTERY_ABOVE,
   input wire logic EXTERNAL_INPUT_PIN,
   input wire logic WATCHDOG_INPUT_PIN,
   input wire logic XT_LEVEL,
   input wire logic SQUARE_WAVE,
   input wire logic AUTOCAL_DONE,
   input wire logic AUTOCAL_RANGE_BAD,
   // Pins, active low interrupts
   output logic PRIMARY_IRQ_PIN_N,
   output logic SECOND_IRQ_PIN_N,
   output logic COUNTDOWN_IRQ_PIN_N,
   output logic CLOCK_OUT_IRQ_PIN_N,
   // Controls toward neighbouring blocks
   output logic WATCHDOG_RESET,
   output logic AUTOCAL_START,
   output logic RC_CAL_LOAD,
   output logic OSC_USE_RC,
   output logic [2:0] ALARM_MATCH_SCOPE,
   output logic COUNTDOWN_RUN,
   output logic COUNTDOWN_REPEAT,
   output logic [1:0] COUNTDOWN_CLOCK_SELECT,
   output logic [1:0] BATTERY_THRESHOLD_SELECT,
   output logic [4:0] WATCHDOG_PERIOD_FIELD
);
   import rtcirq_pkg::*;

   rtcirq_state_t s_q;
   rtcirq_state_t s_d;
   logic xt_slow;
   logic xt_failed;

   // Byte-lane merge for any register write
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // Interrupt pulse width in cycles by code
   function automatic logic [11:0] pulse_len(input logic [1:0] code);
      logic [11:0] r;
      case (code)
         2'h0: r = 12'(`RTCIRQ_PULSE0_CYC);
         2'h1: r = 12'(`RTCIRQ_PULSE1_CYC);
         2'h2: r = 12'(`RTCIRQ_PULSE2_CYC);
         default: r = 12'(`RTCIRQ_PULSE3_CYC);
      endcase
      return r;
   endfunction

   rtcirq_xtmon #(
      .GAP_CYC(XT_GAP_CYC),
      .FAIL_CYC(XT_FAIL_CYC)
   ) u_xtmon (
      .ref_clk(REF_CLK),
      .rstn(RSTN),
      .xt_level(XT_LEVEL),
      .slow(xt_slow),
      .failed(xt_failed)
   );

   // Handshake readies come straight from state
   assign AWREADY = !s_q.aw_got && (s_q.wr_st == WR_IDLE);
   assign WREADY = !s_q.w_got && (s_q.wr_st == WR_IDLE);
   assign ARREADY = !s_q.rvalid;

   always_comb begin
      logic have_aw;
      logic have_w;
      logic [7:0] waddr;
      logic [31:0] wdat;
      logic [3:0] wstb;
      logic [31:0] m;
      logic [31:0] rd;
      logic rd_ok;
      logic [5:0] set_st;
      logic [5:0] clr_st;
      logic set_of;
      logic set_acf;
      logic clr_of;
      logic clr_acf;
      logic in1_sel;
      logic in2_sel;
      logic wd_armed;
      logic alarm_c;
      logic cd_c;
      logic irq;
      logic [35:0] autocal_interval_per;
      s_d = s_q;
      have_aw = s_q.aw_got || (AWVALID && AWREADY);
      have_w = s_q.w_got || (WVALID && WREADY);
      waddr = s_q.aw_got ? s_q.aw_addr : {AWADDR[7:2], 2'h0};
      wdat = s_q.w_got ? s_q.w_data : WDATA;
      wstb = s_q.w_got ? s_q.w_strb : WSTRB;
      m = '0;
      rd = '0;
      rd_ok = 1'b1;
      clr_st = '0;
      clr_of = 1'b0;
      clr_acf = 1'b0;
      s_d.autocal_interval_start = 1'b0;
      s_d.cal_load = 1'b0;
      s_d.wd_reset = 1'b0;

      // Event detection
      in1_sel = EXTERNAL_INPUT_PIN ^ s_q.in1_pol;
      in2_sel = WATCHDOG_INPUT_PIN ^ s_q.in2_pol;
      s_d.in1_sel_q = in1_sel;
      s_d.in2_sel_q = in2_sel;
      s_d.bat_q = BATTERY_ABOVE;
      s_d.xt_failed_q = xt_failed;
      wd_armed = (s_q.wd_period != 5'h00);
      set_st = '0;
      set_st[`RTCIRQ_F_ALARM] = ALARM_MATCH;
      set_st[`RTCIRQ_F_CDOWN] = COUNTDOWN_ZERO && s_q.cd_run;
      set_st[`RTCIRQ_F_WDOG] = WATCHDOG_TIMEOUT && wd_armed;
      // Polarity 0 falling, 1 rising crossing
      set_st[`RTCIRQ_F_BATLO] = s_q.bat_pol ? (BATTERY_ABOVE && !s_q.bat_q)
                                            : (!BATTERY_ABOVE && s_q.bat_q);
      // Edge of pin xor polarity: a polarity change can fire at once
      set_st[`RTCIRQ_F_IN1] = in1_sel && !s_q.in1_sel_q;
      set_st[`RTCIRQ_F_IN2] = in2_sel && !s_q.in2_sel_q;
      set_of = xt_failed && !s_q.xt_failed_q;
      set_acf = AUTOCAL_DONE && AUTOCAL_RANGE_BAD;
      s_d.cal_load = AUTOCAL_DONE && !AUTOCAL_RANGE_BAD;
      s_d.wd_reset = WATCHDOG_TIMEOUT && wd_armed && s_q.wd_steer;

      // Write channel: address and data in either order
      if (s_q.wr_st == WR_IDLE) begin
         if (have_aw && have_w) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.wr_st = WR_RESP;
            s_d.bresp = `RTCIRQ_RESP_OKAY;
            case (waddr)
               `RTCIRQ_OFF_STATUS: begin
                  m = merge({26'h000_0000, s_q.status}, wdat, wstb);
                  clr_st = ~m[5:0];
               end
               `RTCIRQ_OFF_OSCSTAT: begin
                  m = merge({30'h0000_0000, s_q.autocal_fail, s_q.osc_fail}, wdat, wstb);
                  clr_of = !m[0];
                  clr_acf = !m[1];
               end
               `RTCIRQ_OFF_IRQEN: begin
                  m = merge({24'h00_0000, s_q.irq_on}, wdat, wstb);
                  s_d.irq_on = m[7:0] & `RTCIRQ_IRQEN_MASK;
               end
               `RTCIRQ_OFF_CTRL: begin
                  m = merge({20'h0_0000, s_q.sqw_sel, s_q.bat_sel, s_q.bat_pol, s_q.in2_pol,
                             s_q.in1_pol, s_q.auto_clear, s_q.out2_sel, s_q.out1_sel},
                            wdat, wstb);
                  {s_d.sqw_sel, s_d.bat_sel, s_d.bat_pol, s_d.in2_pol, s_d.in1_pol,
                   s_d.auto_clear, s_d.out2_sel, s_d.out1_sel} = m[11:0];
               end
               `RTCIRQ_OFF_OSCCTRL: begin
                  m = merge({28'h000_0000, s_q.autocal_interval, s_q.fail_over, s_q.osc_req}, wdat, wstb);
                  {s_d.autocal_interval, s_d.fail_over, s_d.osc_req} = m[3:0];
                  // Leaving the off code triggers a single run
                  if (s_q.autocal_interval == `RTCIRQ_AUTOCAL_INTERVAL_OFF && m[3:2] != `RTCIRQ_AUTOCAL_INTERVAL_OFF) begin
                     s_d.autocal_interval_start = 1'b1;
                  end
               end
               `RTCIRQ_OFF_TMRCTRL: begin
                  m = merge({16'h0000, s_q.wd_period, s_q.wd_steer, s_q.alarm_scope,
                             s_q.cd_run, s_q.cd_rpt, s_q.cd_clk, s_q.cd_pm, s_q.alarm_pm},
                            wdat, wstb);
                  {s_d.wd_period, s_d.wd_steer, s_d.alarm_scope, s_d.cd_run, s_d.cd_rpt,
                   s_d.cd_clk, s_d.cd_pm, s_d.alarm_pm} = m[15:0];
               end
               `RTCIRQ_OFF_PINLVL: begin
               end
               default: begin
                  s_d.bresp = `RTCIRQ_RESP_SLVERR;
               end
            endcase
         end else begin
            s_d.aw_got = have_aw;
            s_d.w_got = have_w;
            if (!s_q.aw_got) begin
               s_d.aw_addr = {AWADDR[7:2], 2'h0};
            end
            if (!s_q.w_got) begin
               s_d.w_data = WDATA;
               s_d.w_strb = WSTRB;
            end
         end
      end else if (BREADY) begin
         s_d.wr_st = WR_IDLE;
      end

      // Read channel; data captured at the address handshake
      case ({ARADDR[7:2], 2'h0})
         `RTCIRQ_OFF_STATUS: rd = {26'h000_0000, s_q.status};
         `RTCIRQ_OFF_OSCSTAT: rd = {26'h000_0000, s_q.use_rc,
                                    xt_slow || s_q.use_rc,
                                    2'h0, s_q.autocal_fail, s_q.osc_fail};
         `RTCIRQ_OFF_IRQEN: rd = {24'h00_0000, s_q.irq_on};
         `RTCIRQ_OFF_CTRL: rd = {20'h0_0000, s_q.sqw_sel, s_q.bat_sel, s_q.bat_pol,
                                 s_q.in2_pol, s_q.in1_pol, s_q.auto_clear,
                                 s_q.out2_sel, s_q.out1_sel};
         `RTCIRQ_OFF_OSCCTRL: rd = {28'h000_0000, s_q.autocal_interval, s_q.fail_over, s_q.osc_req};
         `RTCIRQ_OFF_TMRCTRL: rd = {16'h0000, s_q.wd_period, s_q.wd_steer, s_q.alarm_scope,
                                    s_q.cd_run, s_q.cd_rpt, s_q.cd_clk, s_q.cd_pm,
                                    s_q.alarm_pm};
         `RTCIRQ_OFF_PINLVL: rd = {30'h0000_0000, WATCHDOG_INPUT_PIN,
                                   EXTERNAL_INPUT_PIN};
         default: rd_ok = 1'b0;
      endcase
      if (ARVALID && ARREADY) begin
         s_d.rvalid = 1'b1;
         s_d.rdata = rd;
         s_d.rresp = rd_ok ? `RTCIRQ_RESP_OKAY : `RTCIRQ_RESP_SLVERR;
         if (s_q.auto_clear && {ARADDR[7:2], 2'h0} == `RTCIRQ_OFF_STATUS) begin
            clr_st = '1;
         end
      end else if (s_q.rvalid && RREADY) begin
         s_d.rvalid = 1'b0;
      end

      // Flags: an event in the clearing cycle survives the clear
      s_d.status = set_st | (s_q.status & ~clr_st);
      s_d.osc_fail = set_of || (s_q.osc_fail && !clr_of);
      s_d.autocal_fail = set_acf || (s_q.autocal_fail && !clr_acf);

      // Oscillator in use follows request, overridden by fail-over
      s_d.use_rc = s_q.osc_req || (s_q.fail_over && xt_failed);

      // Periodic calibration timer, off and reserved codes idle
      autocal_interval_per = (s_q.autocal_interval == `RTCIRQ_AUTOCAL_INTERVAL_SHORT) ? AUTOCAL_INTERVAL_SHORT_CYC : AUTOCAL_INTERVAL_LONG_CYC;
      if (s_q.autocal_interval == `RTCIRQ_AUTOCAL_INTERVAL_LONG || s_q.autocal_interval == `RTCIRQ_AUTOCAL_INTERVAL_SHORT) begin
         if (s_q.autocal_interval_cnt >= autocal_interval_per - 36'h0_0000_0001) begin
            s_d.autocal_interval_cnt = '0;
            s_d.autocal_interval_start = 1'b1;
         end else begin
            s_d.autocal_interval_cnt = s_q.autocal_interval_cnt + 36'h0_0000_0001;
         end
      end else begin
         s_d.autocal_interval_cnt = '0;
      end

      // Pulse shapers; the flag itself stays set in either mode
      if (set_st[`RTCIRQ_F_ALARM] && s_q.alarm_pm != 2'h0) begin
         s_d.alarm_pcnt = pulse_len(s_q.alarm_pm);
      end else if (s_q.alarm_pcnt != 12'h000) begin
         s_d.alarm_pcnt = s_q.alarm_pcnt - 12'h001;
      end
      if (set_st[`RTCIRQ_F_CDOWN] && s_q.cd_pm) begin
         s_d.cd_pcnt = pulse_len(s_q.cd_clk);
      end else if (s_q.cd_pcnt != 12'h000) begin
         s_d.cd_pcnt = s_q.cd_pcnt - 12'h001;
      end

      // Enabled sources combined into one interrupt
      alarm_c = s_q.irq_on[`RTCIRQ_F_ALARM] && ((s_q.alarm_pm == 2'h0) ?
                s_q.status[`RTCIRQ_F_ALARM] : (s_q.alarm_pcnt != 12'h000));
      cd_c = s_q.irq_on[`RTCIRQ_F_CDOWN] && (s_q.cd_pm ? (s_q.cd_pcnt != 12'h000)
             : s_q.status[`RTCIRQ_F_CDOWN]);
      irq = alarm_c || cd_c
            || (s_q.status[`RTCIRQ_F_WDOG] && !s_q.wd_steer && wd_armed)
            || (s_q.status[`RTCIRQ_F_BATLO] && s_q.irq_on[`RTCIRQ_F_BATLO])
            || (s_q.status[`RTCIRQ_F_IN1] && s_q.irq_on[`RTCIRQ_F_IN1])
            || (s_q.status[`RTCIRQ_F_IN2] && s_q.irq_on[`RTCIRQ_F_IN2])
            || (s_q.osc_fail && s_q.irq_on[`RTCIRQ_F_OSCF])
            || (s_q.autocal_fail && s_q.irq_on[`RTCIRQ_F_ACALF]);

      // Pin steering, active low
      case (s_q.out1_sel)
         2'h0: s_d.pin1 = 1'b1;
         2'h1: s_d.pin1 = !irq;
         2'h2: s_d.pin1 = 1'b0;
         default: s_d.pin1 = SQUARE_WAVE;
      endcase
      case (s_q.out2_sel)
         2'h0: s_d.pin2 = 1'b1;
         2'h1: s_d.pin2 = !irq;
         2'h2: s_d.pin2 = 1'b0;
         default: s_d.pin2 = !cd_c;
      endcase
      s_d.pin_cd = !cd_c;
      case (s_q.sqw_sel)
         2'h0: s_d.pin_clk = SQUARE_WAVE;
         2'h1: s_d.pin_clk = !cd_c;
         2'h2: s_d.pin_clk = !irq;
         default: s_d.pin_clk = 1'b1;
      endcase
   end

   // State register; oscillator-fail flag comes up set
   always_ff @(posedge REF_CLK) begin
      if (!RSTN) begin
         s_q <= '0;
         s_q.osc_fail <= 1'b1;
         s_q.out1_sel <= `RTCIRQ_RST_OUT1;
         s_q.out2_sel <= `RTCIRQ_RST_OUT2;
         s_q.pin1 <= 1'b1;
         s_q.pin2 <= 1'b1;
         s_q.pin_cd <= 1'b1;
         s_q.pin_clk <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Registered outputs
   assign BVALID = (s_q.wr_st == WR_RESP);
   assign BRESP = s_q.bresp;
   assign RVALID = s_q.rvalid;
   assign RDATA = s_q.rdata;
   assign RRESP = s_q.rresp;
   assign PRIMARY_IRQ_PIN_N = s_q.pin1;
   assign SECOND_IRQ_PIN_N = s_q.pin2;
   assign COUNTDOWN_IRQ_PIN_N = s_q.pin_cd;
   assign CLOCK_OUT_IRQ_PIN_N = s_q.pin_clk;
   assign WATCHDOG_RESET = s_q.wd_reset;
   assign AUTOCAL_START = s_q.autocal_interval_start;
   assign RC_CAL_LOAD = s_q.cal_load;
   assign OSC_USE_RC = s_q.use_rc;
   assign ALARM_MATCH_SCOPE = s_q.alarm_scope;
   assign COUNTDOWN_RUN = s_q.cd_run;
   assign COUNTDOWN_REPEAT = s_q.cd_rpt;
   assign COUNTDOWN_CLOCK_SELECT = s_q.cd_clk;
   assign BATTERY_THRESHOLD_SELECT = s_q.bat_sel;
   assign WATCHDOG_PERIOD_FIELD = s_q.wd_period;
endmodule

// File: src/rtcirq_xtmon.sv
`timescale 1ns/1ps
`include "rtcirq_regs.svh"

// Crystal activity monitor, works on the sampled crystal level
module rtcirq_xtmon #(
   parameter logic [12:0] GAP_CYC = 13'(`RTCIRQ_XT_GAP_CYC),
   parameter logic [20:0] FAIL_CYC = 21'(`RTCIRQ_XT_FAIL_CYC)
) (
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic xt_level,
   output logic slow,
   output logic failed
);
   import rtcirq_pkg::*;

   rtcirq_xt_t s_q;
   rtcirq_xt_t s_d;

   // Gap since last rising edge; no edge within one 8 kHz period means slow
   always_comb begin
      s_d = s_q;
      s_d.xt_q = xt_level;
      if (xt_level && !s_q.xt_q) begin
         s_d.gap = '0;
      end else if (s_q.gap != GAP_CYC) begin
         s_d.gap = s_q.gap + 13'h0001;
      end
      s_d.slow = (s_q.gap == GAP_CYC);
      // Slow must last the whole window; one good edge restarts it
      if (!s_q.slow) begin
         s_d.slow_cnt = '0;
      end else if (s_q.slow_cnt != FAIL_CYC) begin
         s_d.slow_cnt = s_q.slow_cnt + 21'h00_0001;
      end
      s_d.failed = s_q.slow && (s_q.slow_cnt == FAIL_CYC);
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign slow = s_q.slow;
   assign failed = s_q.failed;
endmodule

// File: test/rtcirq_assertions.sv
`timescale 1ns/1ps

module rtcirq_chk (
   input wire logic REF_CLK,
   input wire logic RSTN,
   input wire logic AWVALID,
   input wire logic AWREADY,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic BREADY,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID,
   input wire logic AUTOCAL_DONE,
   input wire logic AUTOCAL_RANGE_BAD,
   input wire logic RC_CAL_LOAD,
   input wire logic WATCHDOG_RESET,
   input wire logic [4:0] WATCHDOG_PERIOD_FIELD
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);
   // Bus handshakes
   sequence s_wr_take;
      AWVALID && AWREADY && WVALID && WREADY;
   endsequence
   sequence s_rd_take;
      ARVALID && ARREADY;
   endsequence
   a_write_answer: assert property (s_wr_take |=> BVALID) else $error("no write response");
   a_read_answer: assert property (s_rd_take |=> RVALID) else $error("no read response");
   a_read_refuse: assert property (RVALID |-> !ARREADY) else $error("read taken early");
   a_write_refuse: assert property (BVALID |-> !AWREADY && !WREADY)
      else $error("write early");
   a_resp_release: assert property (BVALID && BREADY |=> !BVALID)
      else $error("response stuck");
   // A good result loads the trim for exactly one cycle
   sequence s_load_pulse;
      RC_CAL_LOAD ##1 !RC_CAL_LOAD;
   endsequence
   // A bad range must never reach the trim registers
   a_cal_blocked: assert property (AUTOCAL_DONE && AUTOCAL_RANGE_BAD |=> !RC_CAL_LOAD[*2])
      else $error("bad trim loaded");
   a_cal_loaded: assert property (AUTOCAL_DONE && !AUTOCAL_RANGE_BAD |=> s_load_pulse)
      else $error("trim not loaded");
   a_wdog_gated: assert property (WATCHDOG_RESET |-> WATCHDOG_PERIOD_FIELD != 5'h0)
      else $error("reset with period zero");
endmodule

bind rtcirq_top rtcirq_chk u_chk (.REF_CLK, .RSTN, .AWVALID, .AWREADY, .WVALID, .WREADY,
   .BVALID, .BREADY, .ARVALID, .ARREADY, .RVALID, .AUTOCAL_DONE, .AUTOCAL_RANGE_BAD,
   .RC_CAL_LOAD, .WATCHDOG_RESET, .WATCHDOG_PERIOD_FIELD);

// File: test/rtcirq_xtal_model.sv
`timescale 1ns/1ps

// Crystal seen by the block: a running square wave, or a dead stop
module rtcirq_xtal_model (
   input wire logic clk,
   input wire logic run,
   output logic xt
);
   initial xt = 1'b0;
   // A stopped crystal freezes where it stands, as a dead oscillator would
   always @(posedge clk) begin
      if (run) xt <= ~xt;
   end
endmodule

// File: test/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
   $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); end end

module testbench;
   logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, d;
   logic alarm_flag = 0, cdz = 0, wdt = 0, bat = 1, ext = 0, watchdog_input_pin = 0, acd = 0, acb = 0, xrun = 1;
   logic sqw = 0;
   logic awready, wready, bvalid, arready, rvalid, xt, pin1, pin2, pclk, cdpin, acst, use_rc;
   logic [1:0] bresp, rresp, r;
   int n_mismatch = 0, n_tests = 0, k, n_st = 0, j;
   int exp_st[4] = '{0, 1, 3, 5};
   always #12.5 clk = ~clk;
   // Calibration starts counted in the background
   always @(posedge clk) if (acst === 1'b1) n_st++;
   rtcirq_xtal_model xm (.clk(clk), .run(xrun), .xt(xt));
   rtcirq_top #(.AUTOCAL_INTERVAL_LONG_CYC(36'h00C8), .AUTOCAL_INTERVAL_SHORT_CYC(36'h0064), .XT_GAP_CYC(13'h0014),
      .XT_FAIL_CYC(21'h0032)) dut (.REF_CLK(clk), .RSTN(rstn), .AWADDR(awaddr),
      .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hF), .WVALID(wvalid),
      .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
      .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid),
      .RREADY(rready), .ALARM_MATCH(alarm_flag), .COUNTDOWN_ZERO(cdz), .WATCHDOG_TIMEOUT(wdt),
      .BATTERY_ABOVE(bat), .EXTERNAL_INPUT_PIN(ext), .WATCHDOG_INPUT_PIN(watchdog_input_pin), .XT_LEVEL(xt),
      .SQUARE_WAVE(sqw), .AUTOCAL_DONE(acd), .AUTOCAL_RANGE_BAD(acb),
      .PRIMARY_IRQ_PIN_N(pin1), .SECOND_IRQ_PIN_N(pin2), .COUNTDOWN_IRQ_PIN_N(cdpin),
      .CLOCK_OUT_IRQ_PIN_N(pclk), .WATCHDOG_RESET(), .AUTOCAL_START(acst), .RC_CAL_LOAD(),
      .OSC_USE_RC(use_rc), .ALARM_MATCH_SCOPE(), .COUNTDOWN_RUN(), .COUNTDOWN_REPEAT(),
      .COUNTDOWN_CLOCK_SELECT(), .BATTERY_THRESHOLD_SELECT(), .WATCHDOG_PERIOD_FIELD());

   task automatic results;
      if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Bounded waits: a hang is a mismatch
   task automatic lim;
      if (k >= 50) begin n_mismatch++; results(); end
   endtask

   // Both write channels offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1; k = 0;
      do begin @(posedge clk); k++; end while (!(awready && wready) && k < 50);
      awvalid <= 0; wvalid <= 0;
      do begin @(posedge clk); k++; end while (!bvalid && k < 50);
      r = bresp; bready <= 0; lim(); @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a);
      araddr <= a; arvalid <= 1; rready <= 1; k = 0;
      do begin @(posedge clk); k++; end while (!arready && k < 50);
      arvalid <= 0;
      do begin @(posedge clk); k++; end while (!rvalid && k < 50);
      d = rdata; r = rresp; rready <= 0; lim(); @(posedge clk);
   endtask

   // One-cycle events from alarm, countdown and watchdog
   task automatic pulse(input logic [2:0] m);
      {alarm_flag, cdz, wdt} <= m; @(posedge clk); {alarm_flag, cdz, wdt} <= 3'h0; cyc(3);
   endtask

   // Main sequence
   initial begin
      cyc(12); rstn <= 1; @(posedge clk);
      `CHK(use_rc, 1'b0)
      rd(8'h04); `CHK(d[0], 1'b1)
      wr(8'h08, 32'h0000_0000); wr(8'h00, 32'h0000_0000); wr(8'h04, 32'h0000_0000);
      ext <= 1; cyc(4); rd(8'h00); `CHK(d[5:0], 6'h10)
      `CHK(pin1, 1'b1)
      wr(8'h08, 32'h0000_0010); cyc(2); `CHK(pin1, 1'b0)
      cyc(20); `CHK(pin1, 1'b0)
      wr(8'h00, 32'h0000_0000); cyc(2); `CHK(pin1, 1'b1)
      wr(8'h0C, 32'h0000_0021); wr(8'h00, 32'h0000_0000);
      ext <= 0; cyc(4); rd(8'h00); `CHK(d[4], 1'b1)
      watchdog_input_pin <= 1; cyc(2); rd(8'h18); `CHK(d[1:0], 2'h2)
      wr(8'h0C, 32'h0000_0031); rd(8'h00); `CHK(d[5:0], 6'h30)
      rd(8'h00); `CHK(d[5:0], 6'h00)
      wr(8'h14, 32'h0000_0840); pulse(3'h7); rd(8'h00); `CHK(d[5:0], 6'h07)
      wr(8'h14, 32'h0000_0C40); pulse(3'h1); rd(8'h00); `CHK(d[5:0], 6'h04)
      wr(8'h14, 32'h0000_0000); bat <= 0; pulse(3'h3); rd(8'h00); `CHK(d[5:0], 6'h08)
      // Second pin and clock-out also carry the countdown interrupt
      wr(8'h0C, 32'h0000_0435); wr(8'h08, 32'h0000_0012);
      wr(8'h14, 32'h0000_0040); pulse(3'h2);
      `CHK(cdpin, 1'b0)
      `CHK(pclk, 1'b0)
      `CHK(pin2, 1'b0)
      rd(8'h00); `CHK(d[1], 1'b1)
      // Every interval code, counting calibration starts over a fixed window
      for (j = 0; j < 4; j++) begin
         wr(8'h10, 32'h0000_0000); n_st = 0; wr(8'h10, 32'(j) << 2); cyc(450);
         `CHK(n_st, exp_st[j])
      end
      wr(8'h10, 32'h0000_0000); wr(8'h08, 32'h0000_0080);
      acb <= 1; acd <= 1; @(posedge clk); acd <= 0; cyc(3); `CHK(pin1, 1'b0)
      rd(8'h04); `CHK(d[1], 1'b1)
      acb <= 0; acd <= 1; @(posedge clk); acd <= 0; wr(8'h04, 32'h0000_0000);
      // Crystal stops with fail-over on
      wr(8'h10, 32'h0000_0002); wr(8'h08, 32'h0000_0040); xrun <= 0; cyc(55);
      rd(8'h04); `CHK(d[4], 1'b1)
      `CHK(d[0], 1'b0)
      cyc(20); rd(8'h04); `CHK(d[5:4], 2'h3)
      `CHK(d[0], 1'b1)
      `CHK(use_rc, 1'b1)
      `CHK(pin1, 1'b0)
      xrun <= 1; cyc(10); `CHK(use_rc, 1'b0)
      wr(8'h10, 32'h0000_0001); rd(8'h04); `CHK(d[5:4], 2'h3)
      rd(8'h1C); `CHK(r, 2'h2)
      `CHK(d, 32'h0000_0000)
      wr(8'h1C, 32'h0000_0000); `CHK(r, 2'h2)
      // Square wave on the primary pin overrides the pending interrupt
      wr(8'h0C, 32'h0000_0033); sqw <= 1; cyc(2); `CHK(pin1, 1'b1)
      results();
   end
endmodule
